// [rtl/opss_defines.svh]
`ifndef OPSS_DEFINES_SVH
`define OPSS_DEFINES_SVH
// ==========================================================
// Target address and register map.
`define OPSS_I2C_ADDR 7'h40
`define OPSS_REG_ERROR 8'h01
`define OPSS_REG_RESET 8'h02
`define OPSS_REG_CTRL 8'h03
`define OPSS_REG_CUST_BASE 8'h1c
`define OPSS_REG_CUST_LAST 8'h1f
`define OPSS_REG_RTF 8'hf1
// ==========================================================
// Command values and field positions.
`define OPSS_RTF_KEY 8'h53
`define OPSS_CTRL_LOCK 8'h00
`define OPSS_CTRL_UNLOCK 8'h01
`define OPSS_CTRL_LOAD 8'h04
`define OPSS_CTRL_BURN 8'h08
`define OPSS_CTRL_GUARDED_FUSE_RELOAD 8'h44
`define OPSS_CTRL_UNLOCK_BIT 0
`define OPSS_CTRL_BURN_BIT 3
`define OPSS_CTRL_GUARDED_FUSE_RELOAD_BIT 6
`define OPSS_ERR_SIG_BIT 2
`define OPSS_RST_DSP_BIT 6
`define OPSS_SIG_DIS_BYTE 1
`define OPSS_SIG_DIS_BIT 7
`define OPSS_AMP_LOW_DIS_BYTE 1
`define OPSS_AMP_LOW_DIS_BIT 6
`define OPSS_AMP_HIGH_DIS_BYTE 0
`define OPSS_AMP_HIGH_DIS_BIT 7
`define OPSS_MISR_POLY 8'h1d
`define OPSS_EDGES_SDA 2'h2
`define OPSS_EDGES_SCL 5'h10
// ==========================================================
// Timing.
`define OPSS_MCLK_MHZ 125
`define OPSS_OV_DET_US 50
`define OPSS_WAIT_MS 1
`define OPSS_WIN_MS 1
`define OPSS_BURN_US 10
`define OPSS_PWM_HZ 500
`define OPSS_PWM_STEPS 100
// ==========================================================
// Safe-state duty in percent high.
`define OPSS_DUTY_OSC 7'h00
`define OPSS_DUTY_COIL 7'h14
`define OPSS_DUTY_VCC_UV 7'h28
`define OPSS_DUTY_LDO_UV 7'h3c
`define OPSS_DUTY_SIG 7'h46
`define OPSS_DUTY_AMP_LOW 7'h50
`define OPSS_DUTY_AMP_HIGH 7'h5a
`endif

// [rtl/opss_fuse_mem.sv]
`timescale 1ns/1ns
module opss_fuse_mem
   import opss_pkg::*;
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic wr_en,
   input wire logic [1:0] addr,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata_r
);
   opss_mem_t s_r;
   opss_mem_t s_nxt;

   // ==========================================================
   // Fuse array.
   // Burning only sets bits, as a fuse cannot be unblown. The array is
   // held in flops cleared by reset, so unlike real fuses it does not
   // survive a power cycle.
   always_comb begin
      s_nxt = s_r;
      if (wr_en) begin
         s_nxt.fuse[addr] = s_r.fuse[addr] | wdata;
      end
      s_nxt.rdata = s_r.fuse[addr];
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign rdata_r = s_r.rdata;
endmodule

// [rtl/opss_pkg.sv]
package opss_pkg;
   typedef struct packed {
      logic osc_fail;
      logic coil_open;
      logic vcc_ov;
      logic vcc_uv;
      logic ldo_ov;
      logic ldo_uv;
      logic out_short;
      logic rev_pol;
      logic amp_low;
      logic amp_high;
   } opss_fault_t;
   typedef struct packed {
      logic sin_p_out;
      logic sin_p_oe;
      logic sin_n_oe;
      logic cos_p_oe;
      logic cos_n_oe;
      logic analog_en;
   } opss_pins_t;
   typedef enum logic [2:0] {M_FUNC, M_OVDET, M_WAIT, M_WIN, M_I2C} opss_mode_t;
   typedef enum logic [2:0] {I_IDLE, I_ADDR, I_AACK, I_WR, I_WACK, I_RD, I_RACK} opss_i2c_t;
   typedef enum logic [1:0] {O_LOAD, O_IDLE, O_BURN, O_BWAIT} opss_otp_t;
   typedef struct packed {
      opss_mode_t mode;
      logic [17:0] tmr;
      logic [1:0] sda_cnt;
      logic [4:0] scl_cnt;
      opss_fault_t f1;
      opss_fault_t f2;
      logic [2:0] sda_s;
      logic [2:0] scl_s;
      opss_i2c_t ist;
      logic [3:0] bcnt;
      logic [7:0] sh;
      logic [7:0] tx;
      logic [7:0] ptr;
      logic rw;
      logic first;
      logic nack;
      logic sda_drv;
      logic rtf;
      opss_otp_t ost;
      logic [2:0] idx;
      logic [10:0] bcyc;
      logic unlock;
      logic burning;
      logic guarded_fuse_reload;
      logic [3:0][7:0] cust;
      logic sig_err;
      logic sig_safe;
      logic [11:0] pdiv;
      logic [6:0] pct;
      opss_pins_t pins;
      logic safe;
      logic i2c;
   } opss_state_t;
   typedef struct packed {
      logic [3:0][7:0] fuse;
      logic [7:0] rdata;
   } opss_mem_t;
endpackage

// [rtl/opss_top.sv]
`timescale 1ns/1ns
`include "opss_defines.svh"
// Behaviour
// - Power-up enters functional mode, analog outputs active.
// - Configuration mode answers I2C address 40h.
// - Overvoltage detect, 1 ms wait, 1 ms window.
// - Window needs 2 data and 16 clock edges.
// - Writing 53h at f1h returns to function.
// - After return, only new unlock reopens I2C.
// - Signature error latched until DSP reset write.
// - Burning refused until control unlocked with 01h.
// - Writing 08h burns; burn bit clears itself.
// - Control reads 09h burning, 01h done.
// - Writing 04h loads fuses into shadow bytes.
// - Writing 44h does guarded reload plus load.
// - Faults recover except signature, held until reset.
// - Per-fault PWM duty on sine-positive pin.
// - Safe-state PWM runs at 500 Hz.
// - Listed faults or signalling disabled give high-Z.
// - Amplitude safe states disabled by configuration bits.
module opss_top
   import opss_pkg::*;
#(
   parameter int OV_DET_CYC = `OPSS_OV_DET_US * `OPSS_MCLK_MHZ,
   parameter int WAIT_CYC = `OPSS_WAIT_MS * 1000 * `OPSS_MCLK_MHZ,
   parameter int WIN_CYC = `OPSS_WIN_MS * 1000 * `OPSS_MCLK_MHZ
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire opss_fault_t fault_in,
   input wire logic sin_p_in,
   input wire logic cos_p_in,
   output opss_pins_t pins_r,
   output logic i2c_mode_r,
   output logic safe_state_r
);
   localparam int PWM_STEP_CYC =
      `OPSS_MCLK_MHZ * 1000000 / (`OPSS_PWM_HZ * `OPSS_PWM_STEPS);
   localparam int BURN_CYC = `OPSS_BURN_US * `OPSS_MCLK_MHZ;

   opss_state_t s_r;
   opss_state_t s_nxt;
   logic fw_en;
   logic [1:0] fw_addr;
   logic [7:0] fw_data;
   logic [7:0] frd;

   // ==========================================================
   // Helpers.
   function automatic logic [7:0] misr_step(input logic [7:0] acc, input logic [7:0] b);
      logic [7:0] x;
      x = {acc[6:0], 1'b0} ^ b;
      misr_step = acc[7] ? (x ^ `OPSS_MISR_POLY) : x;
   endfunction

   function automatic logic [7:0] reg_read(input opss_state_t s, input logic [7:0] a);
      reg_read = 8'h00;
      if (a == `OPSS_REG_ERROR) begin
         reg_read[`OPSS_ERR_SIG_BIT] = s.sig_err;
      end else if (a == `OPSS_REG_CTRL) begin
         reg_read[`OPSS_CTRL_UNLOCK_BIT] = s.unlock;
         reg_read[`OPSS_CTRL_BURN_BIT] = s.burning;
         reg_read[`OPSS_CTRL_GUARDED_FUSE_RELOAD_BIT] = s.guarded_fuse_reload;
      end else if (a >= `OPSS_REG_CUST_BASE && a <= `OPSS_REG_CUST_LAST) begin
         reg_read = s.cust[a[1:0]];
      end
   endfunction

   opss_fuse_mem u_fuse (
      .mclk(mclk),
      .resetn(resetn),
      .wr_en(fw_en),
      .addr(fw_addr),
      .wdata(fw_data),
      .rdata_r(frd)
   );

   // ==========================================================
   // Next-state logic.
   always_comb begin
      logic sda;
      logic scl;
      logic start;
      logic stop;
      logic scl_rise;
      logic scl_fall;
      logic reg_wr;
      logic clr_sig;
      logic set_sig;
      logic hz;
      logic pwm;
      logic [6:0] duty;
      logic [7:0] rd;
      logic [7:0] sig;
      opss_fault_t fl;
      sda = s_r.sda_s[1];
      scl = s_r.scl_s[1];
      start = scl && s_r.scl_s[2] && s_r.sda_s[2] && !sda;
      stop = scl && s_r.scl_s[2] && !s_r.sda_s[2] && sda;
      scl_rise = scl && !s_r.scl_s[2];
      scl_fall = !scl && s_r.scl_s[2];
      reg_wr = 1'b0;
      clr_sig = 1'b0;
      set_sig = 1'b0;
      hz = 1'b0;
      pwm = 1'b0;
      duty = 7'h00;
      rd = reg_read(s_r, s_r.ptr);
      sig = 8'h00;
      fl = s_r.f2;
      s_nxt = s_r;
      fw_en = 1'b0;
      fw_addr = s_r.idx[1:0];
      fw_data = s_r.cust[s_r.idx[1:0]];

      // Pins from outside pass two flops before any logic reads them.
      s_nxt.sda_s = {s_r.sda_s[1:0], sin_p_in};
      s_nxt.scl_s = {s_r.scl_s[1:0], cos_p_in};
      s_nxt.f1 = fault_in;
      s_nxt.f2 = s_r.f1;

      // ==========================================================
      // Mode sequencing and unlock window.
      unique case (s_r.mode)
         M_FUNC: begin
            if (fl.vcc_ov) begin
               s_nxt.mode = M_OVDET;
               s_nxt.tmr = 18'h0_0000;
            end
         end
         M_OVDET: begin
            if (!fl.vcc_ov) begin
               s_nxt.mode = M_FUNC;
            end else if (s_r.tmr == 18'(OV_DET_CYC - 1)) begin
               s_nxt.mode = M_WAIT;
               s_nxt.tmr = 18'h0_0000;
            end else begin
               s_nxt.tmr = s_r.tmr + 18'h0_0001;
            end
         end
         M_WAIT: begin
            if (s_r.tmr == 18'(WAIT_CYC - 1)) begin
               s_nxt.mode = M_WIN;
               s_nxt.tmr = 18'h0_0000;
               s_nxt.sda_cnt = 2'h0;
               s_nxt.scl_cnt = 5'h00;
            end else begin
               s_nxt.tmr = s_r.tmr + 18'h0_0001;
            end
         end
         M_WIN: begin
            // Counters saturate so that surplus edges still fail the check.
            if (sda && !s_r.sda_s[2] && s_r.sda_cnt != 2'h3) begin
               s_nxt.sda_cnt = s_r.sda_cnt + 2'h1;
            end
            if (scl_rise && s_r.scl_cnt != 5'h1f) begin
               s_nxt.scl_cnt = s_r.scl_cnt + 5'h01;
            end
            if (s_r.tmr == 18'(WIN_CYC - 1)) begin
               s_nxt.mode = (s_nxt.sda_cnt == `OPSS_EDGES_SDA &&
                             s_nxt.scl_cnt == `OPSS_EDGES_SCL) ? M_I2C : M_FUNC;
            end else begin
               s_nxt.tmr = s_r.tmr + 18'h0_0001;
            end
         end
         M_I2C: begin
         end
      endcase

      // ==========================================================
      // I2C target.
      if (s_r.mode != M_I2C) begin
         s_nxt.ist = I_IDLE;
         s_nxt.sda_drv = 1'b0;
         s_nxt.rtf = 1'b0;
      end else if (start) begin
         s_nxt.ist = I_ADDR;
         s_nxt.bcnt = 4'h0;
         s_nxt.sda_drv = 1'b0;
      end else if (stop) begin
         s_nxt.ist = I_IDLE;
         s_nxt.sda_drv = 1'b0;
      end else if (scl_rise) begin
         if (s_r.ist == I_ADDR || s_r.ist == I_WR || s_r.ist == I_RD) begin
            s_nxt.sh = {s_r.sh[6:0], sda};
            s_nxt.bcnt = s_r.bcnt + 4'h1;
         end
         if (s_r.ist == I_RACK) begin
            s_nxt.nack = sda;
         end
      end else if (scl_fall) begin
         unique case (s_r.ist)
            I_IDLE: begin
            end
            I_ADDR: begin
               if (s_r.bcnt == 4'h8) begin
                  if (s_r.sh[7:1] == `OPSS_I2C_ADDR) begin
                     s_nxt.sda_drv = 1'b1;
                     s_nxt.rw = s_r.sh[0];
                     s_nxt.ist = I_AACK;
                  end else begin
                     s_nxt.ist = I_IDLE;
                  end
               end
            end
            I_AACK: begin
               s_nxt.bcnt = 4'h0;
               if (s_r.rw) begin
                  s_nxt.tx = rd;
                  s_nxt.sda_drv = !rd[7];
                  s_nxt.ist = I_RD;
               end else begin
                  s_nxt.sda_drv = 1'b0;
                  s_nxt.first = 1'b1;
                  s_nxt.ist = I_WR;
               end
            end
            I_WR: begin
               if (s_r.bcnt == 4'h8) begin
                  s_nxt.sda_drv = 1'b1;
                  s_nxt.ist = I_WACK;
                  s_nxt.first = 1'b0;
                  if (s_r.first) begin
                     s_nxt.ptr = s_r.sh;
                  end else begin
                     reg_wr = 1'b1;
                     s_nxt.ptr = s_r.ptr + 8'h01;
                  end
               end
            end
            I_WACK: begin
               s_nxt.sda_drv = 1'b0;
               s_nxt.bcnt = 4'h0;
               s_nxt.ist = I_WR;
               // The mode changes only after the acknowledge has been given.
               if (s_r.rtf) begin
                  s_nxt.mode = M_FUNC;
               end
            end
            I_RD: begin
               if (s_r.bcnt == 4'h8) begin
                  s_nxt.sda_drv = 1'b0;
                  s_nxt.ist = I_RACK;
                  s_nxt.ptr = s_r.ptr + 8'h01;
               end else begin
                  s_nxt.tx = {s_r.tx[6:0], 1'b0};
                  s_nxt.sda_drv = !s_r.tx[6];
               end
            end
            I_RACK: begin
               if (s_r.nack) begin
                  s_nxt.ist = I_IDLE;
               end else begin
                  s_nxt.tx = rd;
                  s_nxt.sda_drv = !rd[7];
                  s_nxt.bcnt = 4'h0;
                  s_nxt.ist = I_RD;
               end
            end
         endcase
      end

      // ==========================================================
      // Register writes.
      if (reg_wr) begin
         if (s_r.ptr == `OPSS_REG_RESET) begin
            clr_sig = s_r.sh[`OPSS_RST_DSP_BIT];
         end else if (s_r.ptr == `OPSS_REG_CTRL && s_r.ost == O_IDLE) begin
            if (s_r.sh == `OPSS_CTRL_UNLOCK) begin
               s_nxt.unlock = 1'b1;
            end else if (s_r.sh == `OPSS_CTRL_LOCK) begin
               s_nxt.unlock = 1'b0;
            end else if (s_r.sh == `OPSS_CTRL_BURN && s_r.unlock) begin
               s_nxt.ost = O_BURN;
               s_nxt.idx = 3'h0;
               s_nxt.burning = 1'b1;
            end else if (s_r.sh == `OPSS_CTRL_LOAD || s_r.sh == `OPSS_CTRL_GUARDED_FUSE_RELOAD) begin
               s_nxt.ost = O_LOAD;
               s_nxt.idx = 3'h0;
               s_nxt.guarded_fuse_reload = s_r.sh[`OPSS_CTRL_GUARDED_FUSE_RELOAD_BIT];
            end
         end else if (s_r.ptr == `OPSS_REG_RTF) begin
            s_nxt.rtf = (s_r.sh == `OPSS_RTF_KEY);
         end else if (s_r.ptr >= `OPSS_REG_CUST_BASE && s_r.ptr <= `OPSS_REG_CUST_LAST &&
                      s_r.ost == O_IDLE) begin
            s_nxt.cust[s_r.ptr[1:0]] = s_r.sh;
         end
      end

      // ==========================================================
      // Fuse load and burn sequencer.
      unique case (s_r.ost)
         O_LOAD: begin
            // Read data trail the address by one cycle.
            if (s_r.idx != 3'h0) begin
               s_nxt.cust[2'(s_r.idx - 3'h1)] = frd;
            end
            if (s_r.idx == 3'h4) begin
               s_nxt.ost = O_IDLE;
               s_nxt.guarded_fuse_reload = 1'b0;
            end else begin
               s_nxt.idx = s_r.idx + 3'h1;
            end
         end
         O_IDLE: begin
         end
         O_BURN: begin
            fw_en = 1'b1;
            if (s_r.idx == 3'h3) begin
               s_nxt.ost = O_BWAIT;
               s_nxt.bcyc = 11'h000;
            end else begin
               s_nxt.idx = s_r.idx + 3'h1;
            end
         end
         O_BWAIT: begin
            if (s_r.bcyc == 11'(BURN_CYC - 1)) begin
               s_nxt.ost = O_IDLE;
               s_nxt.burning = 1'b0;
            end else begin
               s_nxt.bcyc = s_r.bcyc + 11'h001;
            end
         end
      endcase

      // ==========================================================
      // Signature self-test.
      for (int i = 0; i < 3; i++) begin
         sig = misr_step(sig, s_r.cust[i]);
      end
      set_sig = (s_r.ost == O_IDLE) && (sig != s_r.cust[3]);
      s_nxt.sig_err = set_sig || (s_r.sig_err && !clr_sig);
      // Once signalled in functional mode only a power-on reset clears it.
      if (s_r.mode == M_FUNC && s_r.sig_err) begin
         s_nxt.sig_safe = 1'b1;
      end

      // ==========================================================
      // Safe-state PWM timebase, 100 steps per period.
      if (s_r.pdiv == 12'(PWM_STEP_CYC - 1)) begin
         s_nxt.pdiv = 12'h000;
         s_nxt.pct = (s_r.pct == 7'(`OPSS_PWM_STEPS - 1)) ? 7'h00 : s_r.pct + 7'h01;
      end else begin
         s_nxt.pdiv = s_r.pdiv + 12'h001;
      end

      // ==========================================================
      // Output pins.
      // Fault inputs are live levels, so each safe state but the signature one ends with its cause.
      hz = fl.vcc_ov || fl.ldo_ov || fl.out_short || fl.rev_pol;
      pwm = 1'b1;
      if (fl.osc_fail) begin
         duty = `OPSS_DUTY_OSC;
      end else if (fl.coil_open) begin
         duty = `OPSS_DUTY_COIL;
      end else if (fl.vcc_uv) begin
         duty = `OPSS_DUTY_VCC_UV;
      end else if (fl.ldo_uv) begin
         duty = `OPSS_DUTY_LDO_UV;
      end else if (s_nxt.sig_safe) begin
         duty = `OPSS_DUTY_SIG;
      end else if (fl.amp_low &&
                   !s_r.cust[`OPSS_AMP_LOW_DIS_BYTE][`OPSS_AMP_LOW_DIS_BIT]) begin
         duty = `OPSS_DUTY_AMP_LOW;
      end else if (fl.amp_high &&
                   !s_r.cust[`OPSS_AMP_HIGH_DIS_BYTE][`OPSS_AMP_HIGH_DIS_BIT]) begin
         duty = `OPSS_DUTY_AMP_HIGH;
      end else begin
         pwm = 1'b0;
      end
      if (pwm && s_r.cust[`OPSS_SIG_DIS_BYTE][`OPSS_SIG_DIS_BIT]) begin
         hz = 1'b1;
      end
      s_nxt.pins = '0;
      s_nxt.safe = 1'b0;
      s_nxt.i2c = (s_nxt.mode == M_I2C);
      if (s_nxt.mode == M_I2C) begin
         s_nxt.pins.sin_p_oe = s_nxt.sda_drv;
      end else if (s_nxt.mode == M_FUNC) begin
         s_nxt.safe = hz || pwm;
         if (hz) begin
            s_nxt.pins = '0;
         end else if (pwm) begin
            s_nxt.pins.sin_p_oe = 1'b1;
            s_nxt.pins.sin_p_out = (s_nxt.pct < duty);
         end else begin
            s_nxt.pins = '1;
            s_nxt.pins.sin_p_out = 1'b0;
         end
      end
   end

   // ==========================================================
   // State register.
   // The fuse sequencer starts in load so shadow bytes follow the fuses.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         s_r <= '0;
         s_r.mode <= M_FUNC;
         s_r.ist <= I_IDLE;
         s_r.ost <= O_LOAD;
         s_r.sda_s <= 3'h7;
         s_r.scl_s <= 3'h7;
         s_r.pins <= '1;
         s_r.pins.sin_p_out <= 1'b0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign pins_r = s_r.pins;
   assign i2c_mode_r = s_r.i2c;
   assign safe_state_r = s_r.safe;
endmodule

// [tb/opss_i2c_host.sv]
`timescale 1ns/1ns
`include "opss_defines.svh"
module opss_i2c_host
   import opss_pkg::*;
(
   input wire logic mclk,
   input wire opss_pins_t pins_r,
   output logic sda,
   output logic scl
);
   // ====
   // Pull-ups on both lines; an analog drive is taken as not pulling data low.
   logic scl_r = 1'b1;
   logic sda_low_r = 1'b0;
   assign scl = scl_r;
   assign sda = !sda_low_r && !(pins_r.sin_p_oe && !pins_r.sin_p_out && !pins_r.analog_en);
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic xbit(input logic b, output logic s);
      cyc(1);
      sda_low_r = !b;
      cyc(3);
      scl_r = 1'b1;
      cyc(2);
      s = sda;
      cyc(2);
      scl_r = 1'b0;
   endtask
   task automatic xbyte(input logic [7:0] d, input logic a, output logic [7:0] q,
      output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) xbit(d[i], q[i]);
      xbit(a, s);
      ack = !s;
   endtask
   task automatic edge_pair(input logic first);
      cyc(1);
      sda_low_r = !first;
      cyc(3);
      scl_r = 1'b1;
      cyc(4);
      sda_low_r = first;
      cyc(4);
      scl_r = !first;
   endtask
   task automatic wr(input logic [6:0] dev, input logic [7:0] r, input logic [7:0] d,
      output logic ok);
      logic [7:0] q;
      logic a0, a1, a2;
      edge_pair(1'b1);
      xbyte({dev, 1'b0}, 1'b1, q, a0);
      xbyte(r, 1'b1, q, a1);
      xbyte(d, 1'b1, q, a2);
      edge_pair(1'b0);
      ok = a0 && a1 && a2;
   endtask
   task automatic rd(input logic [7:0] r, input int n, output logic [31:0] v);
      logic [7:0] q;
      logic a;
      v = '0;
      edge_pair(1'b1);
      xbyte({`OPSS_I2C_ADDR, 1'b0}, 1'b1, q, a);
      xbyte(r, 1'b1, q, a);
      edge_pair(1'b1);
      xbyte({`OPSS_I2C_ADDR, 1'b1}, 1'b1, q, a);
      for (int i = 0; i < n; i++) begin
         xbyte(8'hff, i == n - 1, q, a);
         v = {v[23:0], q};
      end
      edge_pair(1'b0);
   endtask
   // Edges at 128 cycles a period keep the unlock pulses below 1 MHz.
   task automatic pulses(input int n);
      for (int i = 0; i < 16; i++) begin
         scl_r = 1'b0;
         sda_low_r = i < n;
         cyc(64);
         scl_r = 1'b1;
         sda_low_r = 1'b0;
         cyc(64);
      end
   endtask
endmodule

// [tb/opss_monitor.sv]
`timescale 1ns/1ns
module opss_monitor
   import opss_pkg::*;
#(
   parameter int OV_DET_CYC = 6250,
   parameter int WAIT_CYC = 125000,
   parameter int WIN_CYC = 125000
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire opss_fault_t fault_in,
   input wire logic sin_p_in,
   input wire logic cos_p_in,
   input wire opss_pins_t pins_r,
   input wire logic i2c_mode_r,
   input wire logic safe_state_r
);
   // ====
   // Length of the silent pin run that comes before configuration mode.
   logic [19:0] zc_r;
   logic hzf;
   logic pwmf;
   assign hzf = fault_in.ldo_ov | fault_in.out_short | fault_in.rev_pol;
   assign pwmf = fault_in.osc_fail | fault_in.coil_open | fault_in.vcc_uv | fault_in.ldo_uv;
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         zc_r <= 20'h0_0000;
      end else begin
         zc_r <= (pins_r != '0 || i2c_mode_r) ? 20'h0_0000 : zc_r + 20'h0_0001;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   // ====
   // Amplitude-low and amplitude-high are left out, since configuration bits decide their response.
   sequence s_hz4;
      (hzf && !i2c_mode_r)[*4];
   endsequence
   sequence s_pwm4;
      (pwmf && !hzf && !fault_in.vcc_ov && !i2c_mode_r)[*4];
   endsequence
   a_hz_pins: assert property (s_hz4 |-> pins_r == '0)
      else $error("pins not released under fault");
   a_pwm_pins: assert property (s_pwm4 |-> pins_r[4:0] == 5'h10 && safe_state_r)
      else $error("pwm pin pattern wrong");
   a_safe_pins: assert property (safe_state_r |-> pins_r[4:0] inside {5'h00, 5'h10})
      else $error("safe state drives extra pins");
   a_win_len: assert property ($rose(i2c_mode_r) |->
      zc_r >= WAIT_CYC + WIN_CYC && zc_r <= OV_DET_CYC + WAIT_CYC + WIN_CYC + 8)
      else $error("configuration mode opened at wrong time");
   a_i2c_pins: assert property (i2c_mode_r |-> pins_r[3:0] == 4'h0)
      else $error("analog pins active in configuration mode");
   a_open_drain: assert property (i2c_mode_r && pins_r.sin_p_oe |-> !pins_r.sin_p_out)
      else $error("data pin driven high");
   a_sda_move: assert property ($changed(pins_r.sin_p_oe) && i2c_mode_r &&
      $past(i2c_mode_r) |-> !cos_p_in)
      else $error("data pin moved while clock high");
   a_sda_hold: assert property (i2c_mode_r && $rose(cos_p_in) |->
      ##1 $stable(pins_r.sin_p_oe)[*3])
      else $error("data pin not held through clock high");
endmodule
bind opss_top opss_monitor #(.OV_DET_CYC(OV_DET_CYC), .WAIT_CYC(WAIT_CYC), .WIN_CYC(WIN_CYC))
   u_mon (.mclk(mclk), .resetn(resetn), .fault_in(fault_in), .sin_p_in(sin_p_in),
   .cos_p_in(cos_p_in), .pins_r(pins_r), .i2c_mode_r(i2c_mode_r), .safe_state_r(safe_state_r));

// [tb/tb_top.sv]
`timescale 1ns/1ns
`include "opss_defines.svh"
module tb_top
   import opss_pkg::*;
;
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   opss_fault_t fault_in = '0;
   logic sin_p_in, cos_p_in, i2c_mode_r, safe_state_r, ok;
   opss_pins_t pins_r;
   logic [31:0] q;
   logic [7:0] sig;
   logic [23:0] cfg = 24'h80_005a;
   logic [4:0] fx [10] = '{5'h1f, 5'h10, 5'h00, 5'h00, 5'h10, 5'h00, 5'h10, 5'h00, 5'h10, 5'h10};
   int n_fail = 0;
   int total_checks = 0;
   always #4 mclk = !mclk;
   opss_top #(.OV_DET_CYC(20), .WAIT_CYC(200), .WIN_CYC(4000)) dut (.mclk(mclk),
      .resetn(resetn), .fault_in(fault_in), .sin_p_in(sin_p_in), .cos_p_in(cos_p_in),
      .pins_r(pins_r), .i2c_mode_r(i2c_mode_r), .safe_state_r(safe_state_r));
   opss_i2c_host host (.mclk(mclk), .pins_r(pins_r), .sda(sin_p_in), .scl(cos_p_in));
   // ====
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic wrap_up();
      if (n_fail == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic w(input logic [7:0] r, input logic [7:0] d);
      host.wr(`OPSS_I2C_ADDR, r, d, ok);
   endtask
   task automatic r(input logic [7:0] a, input int n);
      host.rd(a, n, q);
   endtask
   // Supply stays high until the window closes; a refused try then needs a full rerun.
   task automatic unlock(input int n, input logic e);
      int i;
      i = 0;
      fault_in.vcc_ov = 1'b1;
      cyc(240);
      host.pulses(n);
      while (i2c_mode_r !== 1'b1 && i < 4000) begin
         cyc(1);
         i++;
      end
      fault_in.vcc_ov = 1'b0;
      chk("i2c_mode", e, i2c_mode_r);
      if (i2c_mode_r !== e) wrap_up();
      cyc(e ? 20 : 4400);
   endtask
   // ====
   initial begin
      cyc(5);
      resetn = 1'b1;
      cyc(10);
      chk("pins", 6'h1f, pins_r);
      chk("i2c_mode", 0, i2c_mode_r);
      unlock(1, 1'b0);
      chk("pins", 6'h1f, pins_r);
      unlock(2, 1'b1);
      chk("pins", 0, pins_r);
      host.wr(7'h41, 8'h03, 8'h01, ok);
      chk("ack", 0, ok);
      w(8'h03, `OPSS_CTRL_BURN);
      r(8'h03, 1);
      chk("ctrl", 8'h00, q);
      sig = 8'h00;
      for (int i = 0; i < 3; i++) begin
         sig = {sig[6:0], 1'b0} ^ cfg[23 - 8 * i -: 8] ^ (sig[7] ? 8'h1d : 8'h00);
         w(8'(8'h1c + i), cfg[23 - 8 * i -: 8]);
      end
      w(8'h1f, sig);
      w(8'h03, `OPSS_CTRL_UNLOCK);
      r(8'h03, 1);
      chk("ctrl", 8'h01, q);
      w(8'h03, `OPSS_CTRL_BURN);
      r(8'h03, 1);
      chk("ctrl", 8'h09, q);
      for (int k = 0; k < 20 && q[7:0] !== 8'h01; k++) r(8'h03, 1);
      chk("ctrl", 8'h01, q);
      if (q[7:0] !== 8'h01) wrap_up();
      for (int j = 0; j < 2; j++) begin
         for (int i = 0; i < 4; i++) w(8'(8'h1c + i), 8'h00);
         w(8'h03, j ? `OPSS_CTRL_GUARDED_FUSE_RELOAD : `OPSS_CTRL_LOAD);
         r(8'h1c, 4);
         chk("shadow", {cfg, sig}, q);
      end
      r(8'h01, 1);
      chk("sig_err", 1, q[2]);
      w(8'h02, 8'h40);
      r(8'h01, 1);
      chk("sig_err", 0, q[2]);
      w(8'hf1, `OPSS_RTF_KEY);
      chk("ack", 1, ok);
      cyc(10);
      chk("i2c_mode", 0, i2c_mode_r);
      w(8'h03, 8'h01);
      chk("ack", 0, ok);
      chk("pins", 6'h1f, pins_r);
      for (int i = 0; i < 10; i++) begin
         fault_in = opss_fault_t'(10'h001 << i);
         cyc(10);
         chk("fault_pins", fx[i], pins_r[4:0]);
         if (i == 9) chk("pwm_level", 0, pins_r.sin_p_out);
         fault_in = '0;
         cyc(10);
         chk("pins", 6'h1f, pins_r);
      end
      unlock(2, 1'b1);
      w(8'h1f, ~sig);
      w(8'hf1, `OPSS_RTF_KEY);
      cyc(400);
      chk("safe", 1, safe_state_r);
      chk("sig_pins", 5'h10, pins_r[4:0]);
      resetn = 1'b0;
      cyc(5);
      resetn = 1'b1;
      cyc(10);
      chk("pins", 6'h1f, pins_r);
      unlock(2, 1'b1);
      w(8'h1d, 8'h80);
      w(8'h1f, 8'h1d);
      w(8'h02, 8'h40);
      w(8'hf1, `OPSS_RTF_KEY);
      fault_in.amp_low = 1'b1;
      cyc(10);
      chk("dis_pins", 0, pins_r);
      chk("safe", 1, safe_state_r);
      fault_in = '0;
      wrap_up();
   end
endmodule
